// ---- rtl/fmdc_cfg.svh ----
// constants of the fsk modem digital control block
`ifndef FMDC_CFG_SVH
`define FMDC_CFG_SVH

`define FMDC_CLK_HZ       25000000
`define FMDC_MARK_HZ      1200
`define FMDC_SPACE_HZ     2200
`define FMDC_KICK_HZ      1800
`define FMDC_NCO_ONE      64'h0000000001000000
`define FMDC_MARK_INC     24'(64'(`FMDC_MARK_HZ) * `FMDC_NCO_ONE / 64'(`FMDC_CLK_HZ))
`define FMDC_SPACE_INC    24'(64'(`FMDC_SPACE_HZ) * `FMDC_NCO_ONE / 64'(`FMDC_CLK_HZ))
`define FMDC_KICK_CYC     (`FMDC_CLK_HZ / `FMDC_KICK_HZ)
`define FMDC_CD_GAP_US    2500
`define FMDC_CD_GAP_CYC   (`FMDC_CD_GAP_US * (`FMDC_CLK_HZ / 1000000))
`define FMDC_CD_PULSES    3'h4
`define FMDC_RX_SPLIT_CYC (`FMDC_CLK_HZ * 2 / (`FMDC_MARK_HZ + `FMDC_SPACE_HZ))
`define FMDC_WDOG_CYC     2500000

`define FMDC_OFS_CFG      12'h000
`define FMDC_OFS_DAC      12'h004
`define FMDC_OFS_STAT     12'h008

`define FMDC_BIT_KICKSEL  0
`define FMDC_BIT_CORE_DIV 1
`define FMDC_BIT_AUX_DIV  3

`define FMDC_CFG_RST      16'h0000
`define FMDC_DAC_RST      16'h8000

`define FMDC_TONE_HI      8'hc0
`define FMDC_TONE_LO      8'h40
`define FMDC_TONE_IDLE    8'h80

`endif

// ---- rtl/fmdc_modem.sv ----
// fsk modem digital control: transmit tone, carrier, receive, config, clocks, watchdog
`timescale 1ns/1ps
`include "fmdc_cfg.svh"
module fmdc_modem import fmdc_pkg::*; #(
  parameter int CD_GAP_CYC   = `FMDC_CD_GAP_CYC,
  parameter int RX_SPLIT_CYC = `FMDC_RX_SPLIT_CYC,
  parameter int WDOG_CYC     = `FMDC_WDOG_CYC,
  parameter int KICK_CYC     = `FMDC_KICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        logicResetN,
  input  wire logic        sendRequestN,
  input  wire logic        txData,
  input  wire logic        toneIn,
  input  wire logic        carrierPulse,
  input  wire logic        spiClk,
  input  wire logic        spiData,
  input  wire logic        spiSelect,
  input  wire logic        kickIn,
  input  wire logic        jumpStrap,
  output logic      [7:0]  toneOut,
  output logic             txActive,
  output logic             rxBit,
  output logic             carrierPresent,
  output logic             rxBitIdleHigh,
  output logic             auxClockOut,
  output logic             coreClockOut,
  output logic             dacOut
);
  localparam int GW = $clog2(CD_GAP_CYC + 1);
  localparam int PW = $clog2(RX_SPLIT_CYC * 2 + 1);
  localparam int WW = $clog2(WDOG_CYC + 1);
  localparam int KW = $clog2(KICK_CYC);

  if (CD_GAP_CYC < 2 || RX_SPLIT_CYC < 2 || WDOG_CYC < 2 || KICK_CYC < 2) begin : g_bad
    $error("timing counts too small");
  end

  // synchronised pins
  logic [9:0] pinQ;
  logic       logicResetNQ, sendRequestNQ, txDataQ, toneInQ, carrierPulseQ;
  logic       spiClkQ, spiDataQ, spiSelectQ, kickInQ, jumpStrapQ;

  // reset pin starts asserted: hold lasts until its synchroniser settles
  fmdc_sync3 #(.W(10), .RST_VAL(10'h002)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({jumpStrap, kickIn, spiSelect, spiData, spiClk,
           carrierPulse, toneIn, txData, sendRequestN, logicResetN}),
    .q   (pinQ)
  );
  assign {jumpStrapQ, kickInQ, spiSelectQ, spiDataQ, spiClkQ,
          carrierPulseQ, toneInQ, txDataQ, sendRequestNQ, logicResetNQ} = pinQ;

  // logic reset pin registered into a reset for all but the synchroniser and edge detection
  logic holdRst_r, holdRst_nxt, rstAll;
  always_comb begin
    holdRst_nxt = ~logicResetNQ;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) holdRst_r <= 1'b1;
    else holdRst_r <= holdRst_nxt;
  end
  assign rstAll = rst | holdRst_r;

  // edge detection
  logic [4:0] prev_r, prev_nxt;
  logic       spiClkRise, spiSelFall, kickRise, toneRise, cpRise;
  always_comb begin
    prev_nxt = {spiClkQ, spiSelectQ, kickInQ, toneInQ, carrierPulseQ};
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) prev_r <= '0;
    else prev_r <= prev_nxt;
  end
  assign spiClkRise = spiClkQ & ~prev_r[4];
  assign spiSelFall = ~spiSelectQ & prev_r[3];
  assign kickRise   = kickInQ & ~prev_r[2];
  assign toneRise   = toneInQ & ~prev_r[1];
  assign cpRise     = carrierPulseQ & ~prev_r[0];

  // serial configuration port and register bus
  fmdc_spi_state_type spiSt_r, spiSt_nxt;
  fmdc_word_type      spiShift_r, spiShift_nxt, cfg_r, cfg_nxt, dacVal_r, dacVal_nxt;
  logic [4:0]         spiBits_r, spiBits_nxt;
  logic [31:0]        prdata_r, prdata_nxt;
  logic               pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic               apbSetup, apbWrite, spiApply;
  logic               carrier_r, rxBit_r, txActive_r, alarm_r, jumpSel_r;

  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pready_r & pwrite;
  assign spiApply = (spiSt_r == SPI_SHIFT) && spiSelFall &&
                    (spiBits_r == 5'h08 || spiBits_r == 5'h10);

  always_comb begin
    spiSt_nxt    = spiSt_r;
    spiShift_nxt = spiShift_r;
    spiBits_nxt  = spiBits_r;
    cfg_nxt      = cfg_r;
    dacVal_nxt   = dacVal_r;
    pready_nxt   = apbSetup;
    pslverr_nxt  = 1'b0;
    prdata_nxt   = prdata_r;
    unique case (spiSt_r)
      SPI_IDLE: begin
        spiBits_nxt = '0;
        if (spiSelectQ) spiSt_nxt = SPI_SHIFT;
      end
      SPI_SHIFT: begin
        if (spiClkRise && spiBits_r != 5'h1f) begin
          spiShift_nxt = {spiShift_r[14:0], spiDataQ};
          spiBits_nxt  = spiBits_r + 5'h01;
        end
        if (spiSelFall) spiSt_nxt = SPI_IDLE;
      end
    endcase
    if (apbWrite && paddr == `FMDC_OFS_CFG) cfg_nxt = pwdata[15:0];
    if (apbWrite && paddr == `FMDC_OFS_DAC) dacVal_nxt = pwdata[15:0];
    if (spiApply && spiBits_r == 5'h08) cfg_nxt[7:0] = spiShift_r[7:0];
    if (spiApply && spiBits_r == 5'h10) cfg_nxt = spiShift_r;
    if (apbSetup) begin
      prdata_nxt = '0;
      unique case (paddr)
        `FMDC_OFS_CFG:  prdata_nxt = {16'h0000, cfg_r};
        `FMDC_OFS_DAC:  prdata_nxt = {16'h0000, dacVal_r};
        `FMDC_OFS_STAT: prdata_nxt = {27'h0, jumpSel_r, alarm_r, txActive_r,
                                      rxBit_r, carrier_r};
        default:        pslverr_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rstAll) begin
    if (rstAll) begin
      spiSt_r    <= SPI_IDLE;
      spiShift_r <= '0;
      spiBits_r  <= '0;
      cfg_r      <= `FMDC_CFG_RST;
      dacVal_r   <= `FMDC_DAC_RST;
      prdata_r   <= '0;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
    end else begin
      spiSt_r    <= spiSt_nxt;
      spiShift_r <= spiShift_nxt;
      spiBits_r  <= spiBits_nxt;
      cfg_r      <= cfg_nxt;
      dacVal_r   <= dacVal_nxt;
      prdata_r   <= prdata_nxt;
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
    end
  end

  // transmit: phase-continuous oscillator
  logic [23:0] phase_r, phase_nxt;
  logic [7:0]  tone_r, tone_nxt;
  logic        txActive_nxt;
  always_comb begin
    txActive_nxt = ~sendRequestNQ;
    phase_nxt    = phase_r;
    tone_nxt     = `FMDC_TONE_IDLE;
    if (txActive_nxt) begin
      phase_nxt = phase_r + (txDataQ ? `FMDC_MARK_INC : `FMDC_SPACE_INC);
      tone_nxt  = phase_nxt[23] ? `FMDC_TONE_HI : `FMDC_TONE_LO;
    end
  end
  always_ff @(posedge clk or posedge rstAll) begin
    if (rstAll) begin
      phase_r    <= '0;
      tone_r     <= `FMDC_TONE_IDLE;
      txActive_r <= 1'b0;
    end else begin
      phase_r    <= phase_nxt;
      tone_r     <= tone_nxt;
      txActive_r <= txActive_nxt;
    end
  end

  // carrier detect and demodulation
  logic [GW-1:0] gap_r, gap_nxt;
  logic [2:0]    pulses_r, pulses_nxt;
  logic [PW-1:0] period_r, period_nxt;
  logic          rxRaw_r, rxRaw_nxt, carrier_nxt, rxBit_nxt, idleHigh_r, idleHigh_nxt;
  logic          gapOver;
  assign gapOver = gap_r >= GW'(CD_GAP_CYC);
  always_comb begin
    gap_nxt    = gapOver ? gap_r : gap_r + GW'(1);
    pulses_nxt = pulses_r;
    if (cpRise) begin
      gap_nxt = '0;
      if (gapOver) pulses_nxt = 3'h1;
      else if (pulses_r != `FMDC_CD_PULSES) pulses_nxt = pulses_r + 3'h1;
    end else if (gapOver) begin
      pulses_nxt = '0;
    end
    if (!sendRequestNQ) pulses_nxt = '0;
    carrier_nxt = sendRequestNQ && pulses_nxt == `FMDC_CD_PULSES;
    period_nxt  = (period_r == {PW{1'b1}}) ? period_r : period_r + PW'(1);
    rxRaw_nxt   = rxRaw_r;
    if (toneRise) begin
      period_nxt = '0;
      rxRaw_nxt  = period_r >= PW'(RX_SPLIT_CYC);
    end
    rxBit_nxt    = carrier_nxt & rxRaw_nxt;
    idleHigh_nxt = ~carrier_nxt | rxBit_nxt;
  end
  always_ff @(posedge clk or posedge rstAll) begin
    if (rstAll) begin
      gap_r      <= '0;
      pulses_r   <= '0;
      period_r   <= '0;
      rxRaw_r    <= 1'b0;
      carrier_r  <= 1'b0;
      rxBit_r    <= 1'b0;
      idleHigh_r <= 1'b1;
    end else begin
      gap_r      <= gap_nxt;
      pulses_r   <= pulses_nxt;
      period_r   <= period_nxt;
      rxRaw_r    <= rxRaw_nxt;
      carrier_r  <= carrier_nxt;
      rxBit_r    <= rxBit_nxt;
      idleHigh_r <= idleHigh_nxt;
    end
  end

  // two clock dividers, ratio 2 << select
  logic [1:0] clkOut_r;
  for (genvar i = 0; i < 2; i++) begin : g_div
    logic [3:0] cnt_r, cnt_nxt, lim;
    logic       clk_nxt;
    assign lim = (4'h1 << cfg_r[(i == 0 ? `FMDC_BIT_CORE_DIV : `FMDC_BIT_AUX_DIV) +: 2])
                 - 4'h1;
    always_comb begin
      cnt_nxt = cnt_r + 4'h1;
      clk_nxt = clkOut_r[i];
      if (cnt_r >= lim) begin
        cnt_nxt = '0;
        clk_nxt = ~clkOut_r[i];
      end
    end
    always_ff @(posedge clk or posedge rstAll) begin
      if (rstAll) begin
        cnt_r       <= '0;
        clkOut_r[i] <= 1'b0;
      end else begin
        cnt_r       <= cnt_nxt;
        clkOut_r[i] <= clk_nxt;
      end
    end
  end

  // watchdog and alarm strap
  logic [KW-1:0] tick_r, tick_nxt;
  logic [WW-1:0] wd_r, wd_nxt;
  logic          alarm_nxt, strapTaken_r, jumpSel_nxt, kick;
  assign kick = cfg_r[`FMDC_BIT_KICKSEL] ? kickRise : (tick_r == KW'(KICK_CYC - 1));
  always_comb begin
    tick_nxt    = (tick_r == KW'(KICK_CYC - 1)) ? '0 : tick_r + KW'(1);
    wd_nxt      = (wd_r == WW'(WDOG_CYC)) ? wd_r : wd_r + WW'(1);
    alarm_nxt   = alarm_r | (wd_r == WW'(WDOG_CYC));
    jumpSel_nxt = strapTaken_r ? jumpSel_r : jumpStrapQ;
    if (kick) begin
      wd_nxt    = '0;
      alarm_nxt = 1'b0;
    end
  end
  always_ff @(posedge clk or posedge rstAll) begin
    if (rstAll) begin
      tick_r       <= '0;
      wd_r         <= '0;
      alarm_r      <= 1'b0;
      jumpSel_r    <= 1'b0;
      strapTaken_r <= 1'b0;
    end else begin
      tick_r       <= tick_nxt;
      wd_r         <= wd_nxt;
      alarm_r      <= alarm_nxt;
      jumpSel_r    <= jumpSel_nxt;
      strapTaken_r <= 1'b1;
    end
  end

  fmdc_sigdelta #(.W(16)) u_dac (
    .clk       (clk),
    .rst       (rstAll),
    .level     (dacVal_r),
    .force_    (alarm_r),
    .forceHigh (jumpSel_r),
    .bitOut    (dacOut)
  );

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign toneOut        = tone_r;
  assign txActive       = txActive_r;
  assign rxBit          = rxBit_r;
  assign carrierPresent = carrier_r;
  assign rxBitIdleHigh  = idleHigh_r;
  assign coreClockOut   = clkOut_r[0];
  assign auxClockOut    = clkOut_r[1];

  localparam int GAP = CD_GAP_CYC;
  default clocking @(posedge clk); endclocking
  default disable iff (rstAll);

  AST_HOLD: assert property (disable iff (rst) holdRst_r |=>
    !txActive_r && !carrier_r && tone_r == `FMDC_TONE_IDLE)
    else $error("logic not held in reset");
  AST_TX_MODE: assert property (!sendRequestNQ |=> txActive_r)
    else $error("transmit not enabled on request");
  AST_MARK: assert property (!sendRequestNQ && txDataQ |=>
    phase_r == $past(phase_r) + `FMDC_MARK_INC)
    else $error("mark increment wrong");
  AST_SPACE: assert property (!sendRequestNQ && !txDataQ |=>
    phase_r == $past(phase_r) + `FMDC_SPACE_INC)
    else $error("space increment wrong");
  AST_IDLE: assert property (sendRequestNQ |=> tone_r == `FMDC_TONE_IDLE)
    else $error("tone not idle in receive");
  AST_CD_FOUR: assert property ($rose(carrier_r) |->
    pulses_r == `FMDC_CD_PULSES && $past(cpRise))
    else $error("carrier rose without four pulses");
  AST_CD_RX: assert property (carrier_r |-> $past(sendRequestNQ))
    else $error("carrier present while transmitting");
  AST_CD_GAP: assert property (carrier_r |-> $past(gap_r) < GAP)
    else $error("carrier held past pulse gap");
  AST_RX_GATE: assert property (!carrier_r |-> !rxBit_r)
    else $error("receive bit not gated");
  AST_IDLE_HIGH: assert property (idleHigh_r == (!carrier_r || rxBit_r))
    else $error("idle-high output wrong");
  AST_SPI8: assert property (spiApply && spiBits_r == 5'h08 |=>
    cfg_r[7:0] == $past(spiShift_r[7:0]))
    else $error("byte frame not applied");
  AST_KICK: assert property (kick |=> wd_r == '0 && !alarm_r)
    else $error("kick did not restart watchdog");

  COV_CARRIER: cover property ($rose(carrier_r));
  COV_SPI16: cover property (spiApply && spiBits_r == 5'h10);
  COV_ALARM: cover property ($rose(alarm_r));
  COV_TX: cover property ($rose(txActive_r));
endmodule

// ---- rtl/fmdc_pkg.sv ----
// types of the fsk modem digital control block
package fmdc_pkg;
  typedef logic [15:0] fmdc_word_type;
  typedef enum logic {SPI_IDLE, SPI_SHIFT} fmdc_spi_state_type;
endpackage

// ---- rtl/fmdc_sigdelta.sv ----
// first-order sigma-delta converter bitstream with alarm override
`timescale 1ns/1ps
module fmdc_sigdelta import fmdc_pkg::*; #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] level,
  input  wire logic         force_,
  input  wire logic         forceHigh,
  output logic              bitOut
);
  logic [W-1:0] acc_r, acc_nxt;
  logic         out_r, out_nxt;

  if (W < 2) begin : g_bad
    $error("converter width too small");
  end

  always_comb begin
    {out_nxt, acc_nxt} = {1'b0, acc_r} + {1'b0, level};
    if (force_) begin
      out_nxt = forceHigh;
      acc_nxt = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_r <= '0;
      out_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      out_r <= out_nxt;
    end
  end
  assign bitOut = out_r;

  AST_DAC_FORCE: assert property (@(posedge clk) disable iff (rst)
    force_ |=> bitOut == $past(forceHigh))
    else $error("alarm did not force converter output");
endmodule

// ---- rtl/fmdc_sync3.sv ----
// three-stage synchroniser, a change counts once stages two and three agree
`timescale 1ns/1ps
module fmdc_sync3 import fmdc_pkg::*; #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  if (W < 1) begin : g_bad
    $error("sync width must be at least one");
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_r, s2_r, s3_r, q_r, q_nxt;
    always_comb begin
      q_nxt = (s2_r == s3_r) ? s3_r : q_r;
    end
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        s1_r <= RST_VAL[i];
        s2_r <= RST_VAL[i];
        s3_r <= RST_VAL[i];
        q_r  <= RST_VAL[i];
      end else begin
        s1_r <= d[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
        q_r  <= q_nxt;
      end
    end
    assign q[i] = q_r;
  end
endmodule

// ---- testbench/fmdc_host_model.sv ----
// host microcontroller model: serial frames, receive tone, carrier pulses
`timescale 1ns/1ps
module fmdc_host_model (
  input  wire logic clk,
  output logic      toneIn,
  output logic      carrierPulse,
  output logic      spiClk,
  output logic      spiData,
  output logic      spiSelect
);
  int tonePeriod = 0;
  int toneCnt    = 0;
  int cpLeft     = 0;
  int cpTimer    = 0;
  initial begin
    toneIn = 1'b0;
    carrierPulse = 1'b0;
    spiClk = 1'b0;
    spiData = 1'b0;
    spiSelect = 1'b0;
  end
  // square wave at the line tone
  always @(posedge clk) begin
    if (tonePeriod > 0) begin
      toneCnt <= (toneCnt >= tonePeriod - 1) ? 0 : toneCnt + 1;
      if (toneCnt == 0) toneIn <= 1'b1;
      if (toneCnt == tonePeriod / 2) toneIn <= 1'b0;
    end
  end
  // one comparator pulse each 40 cycles
  always @(posedge clk) begin
    cpTimer <= (cpTimer == 39) ? 0 : cpTimer + 1;
    if (cpTimer == 0 && cpLeft > 0) begin
      carrierPulse <= 1'b1;
      cpLeft <= cpLeft - 1;
    end else if (cpTimer == 5) begin
      carrierPulse <= 1'b0;
    end
  end
  task automatic pulses(input int n);
    cpLeft = n;
  endtask
  task automatic send_frame(input logic [15:0] d, input int n);
    @(posedge clk);
    spiSelect <= 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      repeat (6) @(posedge clk);
      spiData <= d[i];
      repeat (6) @(posedge clk);
      spiClk <= 1'b1;
      repeat (6) @(posedge clk);
      spiClk <= 1'b0;
    end
    repeat (6) @(posedge clk);
    spiSelect <= 1'b0;
    spiData <= ~spiData;
  endtask
endmodule

// ---- testbench/tb_top.sv ----
// testbench: bus and pin sequences against the modem control block
`timescale 1ns/1ps
`include "fmdc_cfg.svh"
module tb_top import fmdc_pkg::*; ();
  logic        clk          = 1'b0;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        logicResetN;
  logic        sendRequestN;
  logic        txData;
  logic        kickIn;
  logic        jumpStrap;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        toneIn;
  logic        carrierPulse;
  logic        spiClk;
  logic        spiData;
  logic        spiSelect;
  logic [7:0]  toneOut;
  logic        txActive;
  logic        rxBit;
  logic        carrierPresent;
  logic        rxBitIdleHigh;
  logic        auxClockOut;
  logic        coreClockOut;
  logic        dacOut;
  logic [31:0] rdat;
  logic        err;
  int          n_fail       = 0;
  int          check_count  = 0;
  int          n;
  int          m;
  int          hm;
  always #20 clk = ~clk;
  fmdc_modem #(.CD_GAP_CYC(200), .RX_SPLIT_CYC(100), .WDOG_CYC(500), .KICK_CYC(50)) i_dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .logicResetN(logicResetN), .sendRequestN(sendRequestN), .txData(txData),
    .toneIn(toneIn), .carrierPulse(carrierPulse), .spiClk(spiClk), .spiData(spiData),
    .spiSelect(spiSelect), .kickIn(kickIn), .jumpStrap(jumpStrap), .toneOut(toneOut),
    .txActive(txActive), .rxBit(rxBit), .carrierPresent(carrierPresent),
    .rxBitIdleHigh(rxBitIdleHigh), .auxClockOut(auxClockOut),
    .coreClockOut(coreClockOut), .dacOut(dacOut));
  fmdc_host_model i_host (.clk(clk), .toneIn(toneIn), .carrierPulse(carrierPulse),
    .spiClk(spiClk), .spiData(spiData), .spiSelect(spiSelect));
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic isWrite, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= isWrite;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    // answer taken at the rising edge that shows pready high
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      tally_and_finish;
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdat, err);
  endtask
  task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rdat, err);
    check(name, exp, rdat);
  endtask
  task automatic half_period(output int k);
    logic [7:0] t;
    t = toneOut;
    k = 0;
    while (toneOut === t && k < 12000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 12000) begin
      n_fail++;
      tally_and_finish;
    end
  endtask
  task automatic count_rises(output int c, output int a);
    logic pc;
    logic pa;
    c = 0;
    a = 0;
    @(negedge clk);
    pc = coreClockOut;
    pa = auxClockOut;
    repeat (64) begin
      @(negedge clk);
      c += int'(coreClockOut === 1'b1 && pc === 1'b0);
      a += int'(auxClockOut === 1'b1 && pa === 1'b0);
      pc = coreClockOut;
      pa = auxClockOut;
    end
  endtask
  task automatic count_ones(input int len, output int k);
    k = 0;
    repeat (len) begin
      @(negedge clk);
      k += int'(dacOut === 1'b1);
    end
  endtask
  initial begin
    rst          <= 1'b1;
    psel         <= 1'b0;
    penable      <= 1'b0;
    pwrite       <= 1'b0;
    paddr        <= 12'h000;
    pwdata       <= 32'h0;
    logicResetN  <= 1'b1;
    sendRequestN <= 1'b1;
    txData       <= 1'b0;
    kickIn       <= 1'b0;
    jumpStrap    <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(negedge clk);
    check("tone idle", 8'h80, toneOut);
    check("idle high", 1, rxBitIdleHigh);
    rdc("cfg reset", `FMDC_OFS_CFG, 32'h0);
    rdc("dac reset", `FMDC_OFS_DAC, 32'h8000);
    rdc("stat reset", `FMDC_OFS_STAT, 32'h10);
    apb(1'b0, 12'h00c, 32'h0, rdat, err);
    check("unmapped err", 1, err);
    wr(`FMDC_OFS_CFG, 32'h1a);
    count_rises(n, m);
    check("core div", 16, n);
    check("aux div", 4, m);
    i_host.send_frame(16'h0005, 16);
    repeat (12) @(negedge clk);
    rdc("cfg frame 16", `FMDC_OFS_CFG, 32'h5);
    i_host.send_frame(16'h001a, 8);
    repeat (12) @(negedge clk);
    rdc("cfg frame 8", `FMDC_OFS_CFG, 32'h1a);
    i_host.send_frame(16'h0aa5, 12);
    repeat (12) @(negedge clk);
    rdc("cfg frame 12", `FMDC_OFS_CFG, 32'h1a);
    wr(`FMDC_OFS_DAC, 32'h4000);
    count_ones(256, n);
    check("dac density", 1, n >= 63 && n <= 65);
    @(posedge clk);
    sendRequestN <= 1'b0;
    txData <= 1'b1;
    repeat (8) @(negedge clk);
    i_host.pulses(6);
    check("tx on", 1, txActive);
    half_period(n);
    half_period(n);
    hm = 32'h800000 / `FMDC_MARK_INC;
    check("mark half", 1, n >= hm - 1 && n <= hm + 2);
    check("tone level", 1, toneOut === 8'hc0 || toneOut === 8'h40);
    check("no carrier tx", 0, carrierPresent);
    @(posedge clk);
    txData <= 1'b0;
    half_period(n);
    half_period(n);
    hm = 32'h800000 / `FMDC_SPACE_INC;
    check("space half", 1, n >= hm - 1 && n <= hm + 2);
    @(posedge clk);
    sendRequestN <= 1'b1;
    repeat (8) @(negedge clk);
    check("tx off", 0, txActive);
    check("tone idle rx", 8'h80, toneOut);
    i_host.tonePeriod = 300;
    i_host.pulses(3);
    repeat (140) @(negedge clk);
    check("three pulses", 0, carrierPresent);
    i_host.pulses(100);
    repeat (60) @(negedge clk);
    check("four pulses", 1, carrierPresent);
    repeat (1000) @(negedge clk);
    check("rx mark", 1, rxBit);
    check("enh mark", 1, rxBitIdleHigh);
    i_host.tonePeriod = 50;
    repeat (400) @(negedge clk);
    check("rx space", 0, rxBit);
    check("enh space", 0, rxBitIdleHigh);
    i_host.pulses(0);
    repeat (300) @(negedge clk);
    check("carrier gap", 0, carrierPresent);
    check("rx gated", 0, rxBit);
    check("enh idle", 1, rxBitIdleHigh);
    i_host.pulses(1);
    repeat (80) @(negedge clk);
    check("one pulse", 0, carrierPresent);
    wr(`FMDC_OFS_CFG, 32'h1);
    repeat (600) @(negedge clk);
    rdc("stat alarm", `FMDC_OFS_STAT, 32'h18);
    count_ones(16, n);
    check("dac jump", 16, n);
    @(posedge clk);
    kickIn <= 1'b1;
    repeat (8) @(posedge clk);
    kickIn <= 1'b0;
    repeat (8) @(negedge clk);
    rdc("stat pin kick", `FMDC_OFS_STAT, 32'h10);
    wr(`FMDC_OFS_CFG, 32'h0);
    repeat (1000) @(negedge clk);
    rdc("stat tick kick", `FMDC_OFS_STAT, 32'h10);
    wr(`FMDC_OFS_CFG, 32'h5);
    @(posedge clk);
    sendRequestN <= 1'b0;
    logicResetN <= 1'b0;
    jumpStrap <= 1'b0;
    repeat (10) @(negedge clk);
    check("reset tx", 0, txActive);
    check("reset tone", 8'h80, toneOut);
    @(posedge clk);
    sendRequestN <= 1'b1;
    logicResetN <= 1'b1;
    repeat (10) @(negedge clk);
    rdc("cfg after pin", `FMDC_OFS_CFG, 32'h0);
    wr(`FMDC_OFS_CFG, 32'h1);
    repeat (600) @(negedge clk);
    rdc("stat alarm low", `FMDC_OFS_STAT, 32'h08);
    count_ones(16, n);
    check("dac jump low", 0, n);
    tally_and_finish;
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    tally_and_finish;
  end
endmodule
